// file: rtl/config_port_watchdog.v
// Purpose: index/data configuration port with watchdog logical device
// Assumes: host I/O strobes are already synchronous to clk_sys
// Notes:   expiry drives reset or nmi, chosen by a board strap
`timescale 1ns/1ps
`include "config_port_defs.vh"

module config_port_watchdog #(
    parameter SECOND_CYCLES = `SECOND_CYCLES,
    parameter MINUTE_SECS   = `MINUTE_SECONDS
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // host i/o port
    input  wire [15:0] io_addr,
    input  wire        io_wr,
    input  wire        io_rd,
    input  wire [7:0]  io_wdata,
    output reg  [7:0]  io_rdata,
    output reg         io_rvalid,
    // board strap: high selects nmi
    input  wire        nmi_select_pin,
    // status and expiry
    output reg         ext_mode,
    output reg         wdt_timeout,
    output reg         wdt_reset_out,
    output reg         wdt_nmi_out
);
    // state one-hot codes
    localparam ST_LOCKED = 3'b001;
    localparam ST_HALF   = 3'b010;
    localparam ST_OPEN   = 3'b100;

    reg  [2:0] state_reg;
    reg  [2:0] state_next;
    reg  [7:0] index_reg;
    reg  [7:0] ldev_reg;
    reg  [7:0] wdt_ctrl_reg;
    reg  [7:0] wdt_count_reg;
    reg        running_reg;
    reg        nmi_sel_meta;
    reg        nmi_sel_sync;
    reg        load_pulse;
    reg  [7:0] load_val_reg;
    reg  [7:0] rdata_next;

    // next values of the counter and expiry flags
    reg  [7:0] wdt_count_next;
    reg        running_next;
    reg        wdt_timeout_next;
    reg        wdt_reset_next;
    reg        wdt_nmi_next;

    wire idx_wr  = io_wr && (io_addr == `INDEX_PORT_ADDR);
    wire dat_wr  = io_wr && (io_addr == `DATA_PORT_ADDR);
    wire dat_rd  = io_rd && (io_addr == `DATA_PORT_ADDR);
    wire is_open = (state_reg == ST_OPEN);
    wire wdt_sel = (ldev_reg == `WDT_LDEV_NUMBER);
    wire tick;

    wire open_idx_wr = is_open && idx_wr;
    wire open_dat_wr = is_open && dat_wr;
    wire open_dat_rd = is_open && dat_rd;
    // lock byte is a command, not an index
    wire index_load  = open_idx_wr && (io_wdata != `LOCK_BYTE);
    wire hit_ldev    = (index_reg == `LDEV_SELECT_INDEX);
    wire hit_ctrl    = wdt_sel && (index_reg == `WDT_CONTROL_INDEX);
    wire hit_count   = wdt_sel && (index_reg == `WDT_COUNT_INDEX);

    // data-port writes that land in a register
    wire wr_ldev     = open_dat_wr && hit_ldev;
    wire wr_ctrl     = open_dat_wr && hit_ctrl;
    wire wr_count    = open_dat_wr && hit_count;
    // this cycle's tick empties the count
    wire expire_now  = running_reg && tick && (wdt_count_reg == 8'h01);

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_LOCKED: begin
                if (idx_wr && io_wdata == `UNLOCK_BYTE) begin
                    state_next = ST_HALF;
                end
            end
            ST_HALF: begin
                // any other port write breaks the pair
                if (idx_wr && io_wdata == `UNLOCK_BYTE) begin
                    state_next = ST_OPEN;
                end else if (io_wr) begin
                    state_next = ST_LOCKED;
                end
            end
            ST_OPEN: begin
                if (idx_wr && io_wdata == `LOCK_BYTE) begin
                    state_next = ST_LOCKED;
                end
            end
            default: begin
                state_next = ST_LOCKED;
            end
        endcase
    end

    // mode state only; the other registers sit in separate processes
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= ST_LOCKED;
        end else begin
            state_reg <= state_next;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            index_reg <= 8'h00;
        end else if (index_load) begin
            index_reg <= io_wdata;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ldev_reg <= 8'h00;
        end else if (wr_ldev) begin
            ldev_reg <= io_wdata;
        end
    end

    // device register write
    // other control bits are stored only
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wdt_ctrl_reg <= `WDT_CONTROL_RESET;
        end else if (wr_ctrl) begin
            wdt_ctrl_reg <= io_wdata;
        end
    end

    // count load starts
    // byte parks in load_val_reg, applied one edge later
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            load_pulse   <= 1'b0;
            load_val_reg <= 8'h00;
        end else begin
            load_pulse <= wr_count;
            if (wr_count) begin
                load_val_reg <= io_wdata;
            end
        end
    end

    // byte read of selected register
    // locked or unmapped reads give zero
    always @* begin
        rdata_next = 8'h00;
        if (open_dat_rd) begin
            case (index_reg)
                `LDEV_SELECT_INDEX: begin
                    rdata_next = ldev_reg;
                end
                `WDT_CONTROL_INDEX: begin
                    if (wdt_sel) begin
                        rdata_next = wdt_ctrl_reg;
                    end
                end
                `WDT_COUNT_INDEX: begin
                    if (wdt_sel) begin
                        rdata_next = wdt_count_reg;
                    end
                end
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    // rvalid pulses even when locked, so a host read never stalls
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            io_rdata  <= 8'h00;
            io_rvalid <= 1'b0;
        end else begin
            io_rdata  <= rdata_next;
            io_rvalid <= dat_rd;
        end
    end

    // strap is a pin: two flops first
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            nmi_sel_meta <= 1'b0;
            nmi_sel_sync <= 1'b0;
        end else begin
            nmi_sel_meta <= nmi_select_pin;
            nmi_sel_sync <= nmi_sel_meta;
        end
    end

    wdt_tick_gen #(
        .SECOND_CYCLES (SECOND_CYCLES),
        .MINUTE_SECS   (MINUTE_SECS)
    ) u_tick (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .restart      (load_pulse),
        .unit_minutes (wdt_ctrl_reg[`WDT_UNIT_BIT]),
        .tick         (tick)
    );

    always @* begin
        wdt_count_next = wdt_count_reg;
        running_next   = running_reg;
        if (load_pulse) begin
            wdt_count_next = load_val_reg;
            running_next   = (load_val_reg != 8'h00);
        end else if (running_reg && tick) begin
            wdt_count_next = wdt_count_reg - 8'h01;
            if (expire_now) begin
                running_next = 1'b0;
            end
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wdt_count_reg <= `WDT_COUNT_RESET;
            running_reg   <= 1'b0;
        end else begin
            wdt_count_reg <= wdt_count_next;
            running_reg   <= running_next;
        end
    end

    // strap picks reset or nmi
    // expiry beats a reload in one cycle: a late kick is still a miss
    always @* begin
        wdt_timeout_next = wdt_timeout;
        wdt_reset_next   = wdt_reset_out;
        wdt_nmi_next     = wdt_nmi_out;
        if (expire_now) begin
            wdt_timeout_next = 1'b1;
            wdt_reset_next   = ~nmi_sel_sync;
            wdt_nmi_next     = nmi_sel_sync;
        end else if (load_pulse) begin
            wdt_timeout_next = 1'b0;
            wdt_reset_next   = 1'b0;
            wdt_nmi_next     = 1'b0;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wdt_timeout   <= 1'b0;
            wdt_reset_out <= 1'b0;
            wdt_nmi_out   <= 1'b0;
        end else begin
            wdt_timeout   <= wdt_timeout_next;
            wdt_reset_out <= wdt_reset_next;
            wdt_nmi_out   <= wdt_nmi_next;
        end
    end

    // mirrors the state the edge takes, so it tracks state_reg
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ext_mode <= 1'b0;
        end else begin
            ext_mode <= (state_next == ST_OPEN);
        end
    end
endmodule // config_port_watchdog

// file: rtl/config_port_defs.vh
// Purpose: constants for the configuration port and watchdog
// Assumes: 20 MHz system clock
// Notes:   offsets are byte I/O addresses and config indexes
`ifndef CONFIG_PORT_DEFS_VH
`define CONFIG_PORT_DEFS_VH

`define INDEX_PORT_ADDR     16'h002E
`define DATA_PORT_ADDR      16'h002F
`define UNLOCK_BYTE         8'h87
`define LOCK_BYTE           8'hAA
`define LDEV_SELECT_INDEX   8'h07
`define WDT_LDEV_NUMBER     8'h08
`define WDT_CONTROL_INDEX   8'hF5
`define WDT_COUNT_INDEX     8'hF6
`define WDT_UNIT_BIT        3
`define WDT_CONTROL_RESET   8'h00
`define WDT_COUNT_RESET     8'h00
`define CLK_HZ              20000000
`define SECOND_NS           1000000000
`define MINUTE_SECONDS      60
`define SECOND_CYCLES       (`CLK_HZ)

`endif

// file: rtl/wdt_tick_gen.v
// Purpose: one-cycle tick once per selected watchdog time unit
// Assumes: clk_sys domain, unit_minutes from a register
// Notes:   restart realigns the unit boundary on a count load
`timescale 1ns/1ps
`include "config_port_defs.vh"
module wdt_tick_gen #(
    parameter SECOND_CYCLES = `SECOND_CYCLES,
    parameter MINUTE_SECS   = `MINUTE_SECONDS
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // control
    input  wire        restart,
    input  wire        unit_minutes,
    // output
    output reg         tick
);
    reg  [31:0] cycle_reg;
    reg  [7:0]  sec_reg;
    wire        sec_end  = (cycle_reg == SECOND_CYCLES - 1);
    wire        min_end  = (sec_reg == MINUTE_SECS - 1);

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cycle_reg <= 32'h00000000;
            sec_reg   <= 8'h00;
            tick      <= 1'b0;
        end else if (restart) begin
            cycle_reg <= 32'h00000000;
            sec_reg   <= 8'h00;
            tick      <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (sec_end) begin
                cycle_reg <= 32'h00000000;
                if (!unit_minutes) begin
                    tick    <= 1'b1;
                    sec_reg <= 8'h00;
                end else if (min_end) begin
                    tick    <= 1'b1;
                    sec_reg <= 8'h00;
                end else begin
                    sec_reg <= sec_reg + 8'h01;
                end
            end else begin
                cycle_reg <= cycle_reg + 32'h00000001;
            end
        end
    end
endmodule // wdt_tick_gen

// file: tb/cpw_asserts.sv
// Purpose: port checks for config_port_watchdog
// Assumes: single clk_sys domain
// Notes:   strap held steady around expiry
`timescale 1ns/1ps
module cpw_asserts (
    // clock and reset
    input logic        clk_sys,
    input logic        rst,
    // host port
    input logic [15:0] io_addr,
    input logic        io_wr,
    input logic        io_rd,
    input logic [7:0]  io_wdata,
    input logic [7:0]  io_rdata,
    input logic        io_rvalid,
    // status
    input logic        ext_mode,
    input logic        wdt_timeout,
    input logic        wdt_reset_out,
    input logic        wdt_nmi_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire rd_d = io_rd && io_addr == 16'h002F;
    wire w87  = io_wr && io_addr == 16'h002E && io_wdata == 8'h87;
    wire waa  = io_wr && io_addr == 16'h002E && io_wdata == 8'hAA;
    property p_rvalid; rd_d |=> io_rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("no read answer");
    property p_quiet; !rd_d |=> !io_rvalid && io_rdata == 8'h00; endproperty
    a_quiet: assert property (p_quiet) else $error("stray read answer");
    property p_unlock; w87 ##1 w87 |=> ext_mode; endproperty
    a_unlock: assert property (p_unlock) else $error("unlock missed");
    property p_open; $rose(ext_mode) |-> $past(w87); endproperty
    a_open: assert property (p_open) else $error("mode opened without unlock");
    property p_lock; ext_mode && waa |=> !ext_mode; endproperty
    a_lock: assert property (p_lock) else $error("lock missed");
    property p_close; $fell(ext_mode) |-> $past(waa); endproperty
    a_close: assert property (p_close) else $error("mode closed without lock");
    property p_expiry; wdt_timeout == (wdt_reset_out ^ wdt_nmi_out); endproperty
    a_expiry: assert property (p_expiry) else $error("expiry outputs disagree");
    property p_clear; $fell(wdt_timeout) |-> $past(io_wr && io_addr == 16'h002F, 2); endproperty
    a_clear: assert property (p_clear) else $error("timeout dropped alone");
    c_unlock: cover property (w87 ##1 w87);
    c_expiry: cover property ($rose(wdt_timeout));
    c_read: cover property (io_rvalid);
endmodule // cpw_asserts

bind config_port_watchdog cpw_asserts chk_u (.clk_sys(clk_sys), .rst(rst), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .ext_mode(ext_mode), .wdt_timeout(wdt_timeout), .wdt_reset_out(wdt_reset_out),
    .wdt_nmi_out(wdt_nmi_out));

// file: tb/io_host_model.sv
// Purpose: host cpu issuing byte i/o cycles
// Assumes: strobes launched 2 ns after clk_sys rise
// Notes:   released lines show inverted values, not stale ones
`timescale 1ns/1ps
module io_host_model (
    // clock
    input  wire        clk_sys,
    // host i/o port
    output reg  [15:0] io_addr = 16'h0000,
    output reg         io_wr = 1'b0,
    output reg         io_rd = 1'b0,
    output reg  [7:0]  io_wdata = 8'h00
);
    // byte cycle at index or data port
    // n above one gives back-to-back writes
    task acc(input [15:0] a, input [7:0] d, input w, input integer n);
        @(posedge clk_sys);
        #2;
        io_addr = a;
        io_wdata = d;
        io_wr = w;
        io_rd = !w;
        repeat (n) @(posedge clk_sys);
        #2;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = ~a;
        io_wdata = ~d;
    endtask
endmodule // io_host_model

// file: tb/tb.sv
// Purpose: self-checking bench for config_port_watchdog
// Assumes: shortened unit counts
// Notes:   read answers matched against a queue of expectations
`timescale 1ns/1ps
module tb;
    localparam SEC = 10;
    localparam MIN = 3;
    reg         clk_sys = 1'b0;
    reg         rst = 1'b1;
    reg         nmi_select_pin = 1'b0;
    wire [15:0] io_addr;
    wire [7:0]  io_wdata;
    wire [7:0]  io_rdata;
    wire        io_wr, io_rd, io_rvalid, ext_mode;
    wire        wdt_timeout, wdt_reset_out, wdt_nmi_out;
    integer     errors = 0;
    integer     comparisons = 0;
    integer     seed = 32'h48CDF605;
    integer     n;
    reg  [7:0]  ctl;
    reg  [7:0]  exp_q[$];
    always #25 clk_sys = ~clk_sys;
    io_host_model host_u (.clk_sys(clk_sys), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata));
    config_port_watchdog #(.SECOND_CYCLES(SEC), .MINUTE_SECS(MIN)) dut_u (.clk_sys(clk_sys),
        .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rvalid(io_rvalid), .nmi_select_pin(nmi_select_pin),
        .ext_mode(ext_mode), .wdt_timeout(wdt_timeout), .wdt_reset_out(wdt_reset_out),
        .wdt_nmi_out(wdt_nmi_out));
    task check(input [63:0] nm, input [7:0] seen, input [7:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("ERROR %0s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task conclude;
        if (errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task cyc(input integer k);
        repeat (k) @(posedge clk_sys);
        #2;
    endtask
    task wr(input [15:0] a, input [7:0] d);
        host_u.acc(a, d, 1'b1, 1);
    endtask
    task rd(input [7:0] e);
        exp_q.push_back(e);
        host_u.acc(16'h002F, 8'h00, 1'b0, 1);
    endtask
    task rr(input [7:0] i, input [7:0] e);
        wr(16'h002E, i);
        rd(e);
    endtask
    task cw(input [7:0] i, input [7:0] d);
        wr(16'h002E, i);
        wr(16'h002F, d);
    endtask
    // bounded wait; expiry must land inside lo..hi cycles
    task wait_to(input integer lo, input integer hi);
        n = 0;
        do begin
            cyc(1);
            n = n + 1;
        end while (wdt_timeout !== 1'b1 && n < 300);
        if (n >= 300) begin
            check("timeout", 8'h00, 8'h01);
            conclude;
        end else
            check("expiry", n >= lo && n <= hi, 8'h01);
    endtask
    always @(negedge clk_sys)
        if (io_rvalid === 1'b1) begin
            if (exp_q.size() == 0)
                check("rvalid", 8'h01, 8'h00);
            else
                check("rdata", io_rdata, exp_q.pop_front());
        end
    initial begin
        cyc(16);
        rst = 1'b0;
        check("ext", ext_mode, 8'h00);
        check("tmo", {wdt_timeout, wdt_reset_out, wdt_nmi_out}, 8'h00);
        rd(8'h00);
        cw(8'h07, 8'h05);
        wr(16'h002E, 8'h87);
        wr(16'h002E, 8'h07);
        wr(16'h002E, 8'h87);
        check("ext", ext_mode, 8'h00);
        host_u.acc(16'h002E, 8'h87, 1'b1, 2);
        wr(16'h002E, 8'h20);
        check("ext", ext_mode, 8'h01);
        rd(8'h00);
        rr(8'h07, 8'h00);
        rr(8'hF6, 8'h00);
        cw(8'h07, 8'h08);
        rr(8'h07, 8'h08);
        rr(8'hF5, 8'h00);
        ctl = $random(seed);
        cw(8'hF5, ctl);
        rr(8'hF5, ctl);
        cw(8'hF5, ctl & 8'hF7);
        rr(8'hF5, ctl & 8'hF7);
        cw(8'hF6, 8'h03);
        wait_to(3 * SEC - 3, 3 * SEC + 6);
        check("rst_out", {wdt_nmi_out, wdt_reset_out}, 8'h01);
        rr(8'hF6, 8'h00);
        cw(8'hF5, ctl | 8'h08);
        cw(8'hF6, 8'h02);
        nmi_select_pin = 1'b1;
        wait_to(2 * MIN * SEC - 3, 2 * MIN * SEC + 6);
        check("nmi_out", {wdt_nmi_out, wdt_reset_out}, 8'h02);
        cw(8'hF6, 8'h00);
        cyc(2);
        check("tmo", wdt_timeout, 8'h00);
        cyc(MIN * SEC + 5);
        rr(8'hF6, 8'h00);
        wr(16'h002E, 8'hAA);
        cyc(1);
        check("ext", ext_mode, 8'h00);
        cw(8'hF6, 8'h01);
        cyc(3 * SEC + 20);
        check("tmo", wdt_timeout, 8'h00);
        rd(8'h00);
        cyc(2);
        check("pending", exp_q.size() != 0, 8'h00);
        conclude;
    end
endmodule // tb
